// ### rtl/prd_pkg.sv
// What this block does
// R1 - Cyclic conversion refreshes 13-bit output every 500 us
// R2 - Device is slave only, drives on request
// R3 - Idle bus: nobody pulls SCL or SDA
// R4 - Master opens requests with start, SDA falls
// R5 - Master ends with stop, SDA rises
// R6 - Repeated start without stop is new request
// R7 - SDA changes only while SCL low
// R8 - Bytes of eight bits, MSB first
// R9 - Receiver pulls SDA low on ninth pulse
// R10 - Master nack: device releases, master repeats/stops
// R11 - Device answers fixed address 1111000
// R12 - Optional factory secondary address answered too
// R13 - Address byte: seven bits plus direction
// R14 - Read returns two bytes, 15-bit value; the code sends the 13-bit value with three zero bits above it
// R15 - Master clocks SCL 100 to 400 kHz
// R16 - Pressure to output delay about 2 ms
// R17 - Value captured at read start, MSB byte first
// R18 - Unmatched address not acknowledged, SDA released
package prd_pkg;

   // Core clock rate
   localparam int unsigned CLK_SYS_MHZ = 100;

   // Conversion timing
   localparam int unsigned CONV_PERIOD_US = 500;
   localparam int unsigned CONV_CYCLES = CONV_PERIOD_US * CLK_SYS_MHZ;
   localparam int unsigned RESP_DELAY_US = 2000;
   localparam int unsigned RESP_STAGES = RESP_DELAY_US / CONV_PERIOD_US;

   // Data widths
   localparam int unsigned PRES_W = 13;
   localparam int unsigned INFO_W = 15;
   localparam int unsigned TX_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 7;

   // Addresses and bit values
   localparam logic [ADDR_W-1:0] ADDR_PRIMARY = 7'h78;
   localparam logic [ADDR_W-1:0] SEC_ADDR_DEF = 7'h28;
   localparam logic DIR_RD = 1'b1;
   localparam logic ACK_BIT = 1'b0;
   localparam logic NACK_BIT = 1'b1;

   // Master bus rate, four quarters per SCL period
   localparam int unsigned SCL_KHZ = 100;
   localparam int unsigned SCL_QUARTER_CYCLES = (CLK_SYS_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);

   // Receive buffer
   localparam int unsigned FIFO_DEPTH = 16;

   // Device link states
   typedef enum logic [2:0] {
      DEV_IDLE = 3'b000,
      DEV_ADDR = 3'b001,
      DEV_AACK = 3'b010,
      DEV_TX = 3'b011,
      DEV_MACK = 3'b100,
      DEV_IGNORE = 3'b101
   } prd_dev_st_e;

   // Master engine states
   typedef enum logic [2:0] {
      MST_IDLE = 3'b000,
      MST_START = 3'b001,
      MST_XFER = 3'b010,
      MST_RSTART = 3'b011,
      MST_STOP = 3'b100
   } prd_mst_st_e;

endpackage

// ### rtl/prd_link_if.sv
`timescale 1ns/1ps
interface prd_link_if;
   // Resolved wire levels
   logic scl;
   logic sda;
   // Master pin drivers, enable active low
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   // Device pin drivers, enable active low
   logic s_sda_o;
   logic s_sda_oe_n;

   // Open-drain wire with pull-up
   assign scl = m_scl_oe_n | m_scl_o;
   assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

   modport master (input scl, input sda, output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n);
   modport device (input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface

// ### rtl/prd_device.sv
`timescale 1ns/1ps
module prd_device #(
   // Core cycles between two conversions
   parameter int unsigned CONV_CYCLES = prd_pkg::CONV_CYCLES,
   // Factory secondary address
   parameter bit SEC_ADDR_EN = 1'b0,
   parameter logic [prd_pkg::ADDR_W-1:0] SEC_ADDR = prd_pkg::SEC_ADDR_DEF
) (
   // Core clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Raw sample from the sensing front end
   input wire logic [prd_pkg::PRES_W-1:0] pressure_i,
   // Output register and conversion strobe
   output logic [prd_pkg::PRES_W-1:0] pres_out_o,
   output logic conv_done_o,
   // Two-wire bus, device end
   prd_link_if.device link
);

   localparam int unsigned CW = $clog2(CONV_CYCLES);
   localparam int unsigned NST = prd_pkg::RESP_STAGES;
   localparam int unsigned PW = prd_pkg::PRES_W;
   localparam int unsigned TW = prd_pkg::TX_W;
   localparam int unsigned AW = prd_pkg::ADDR_W;

   // Core domain state
   typedef struct packed {
      logic [CW-1:0] tick;
      logic [NST-1:0][PW-1:0] hist;
      logic [PW-1:0] outv;
      logic done;
      logic [2:0] req_s;
      logic [PW-1:0] snap;
      logic ack;
   } prd_core_s;

   // Link domain state, clocked by falling SCL
   typedef struct packed {
      prd_pkg::prd_dev_st_e st;
      logic [2:0] cnt;
      logic [AW-1:0] sh;
      logic rd;
      logic byt;
      logic [TW-1:0] tx;
      logic sda_oe_n;
      logic req;
      logic [1:0] ack_s;
      logic seen;
   } prd_link_s;

   prd_core_s c_q;
   prd_core_s c_d;
   prd_link_s l_q;
   prd_link_s l_d;
   logic sda_hi_q;
   logic start_tgl_q;
   logic start_w;
   logic hit_w;
   logic [TW-1:0] word_w;

   // Conversion tick, response pipeline and snapshot handshake
   always_comb begin
      c_d = c_q;
      c_d.done = 1'b0;
      c_d.req_s = {c_q.req_s[1:0], l_q.req};
      if (c_q.tick == CW'(CONV_CYCLES - 1)) begin
         c_d.tick = '0; // R1
         c_d.hist = {c_q.hist[NST-2:0], pressure_i}; // R16
         c_d.outv = c_q.hist[NST-1]; // R16
         c_d.done = 1'b1; // R1
      end else begin
         c_d.tick = c_q.tick + 1'b1;
      end
      // Freeze one sample per read request
      if (c_q.req_s[2] ^ c_q.req_s[1]) begin
         c_d.snap = c_q.outv; // R17
         c_d.ack = ~c_q.ack;
      end
   end

   // Core domain registers
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   // SDA level seen at SCL rise, for bit sampling
   always_ff @(posedge link.scl or negedge nrst_i) begin
      if (!nrst_i) begin
         sda_hi_q <= 1'b1;
      end else begin
         sda_hi_q <= link.sda;
      end
   end

   // Toggles on each SDA fall while SCL is high, repeated starts included
   always_ff @(negedge link.sda or negedge nrst_i) begin
      if (!nrst_i) begin
         start_tgl_q <= 1'b0;
      end else if (link.scl) begin
         start_tgl_q <= ~start_tgl_q; // R4
      end
   end

   // Start pending until the next SCL fall takes it
   assign start_w = start_tgl_q ^ l_q.seen; // R4 R6

   // Primary or factory address
   assign hit_w = (l_q.sh == prd_pkg::ADDR_PRIMARY) || (SEC_ADDR_EN && (l_q.sh == SEC_ADDR)); // R11 R12

   // Snapshot only once the core has answered the request
   assign word_w = (l_q.ack_s[1] == l_q.req) ? {{(TW - PW){1'b0}}, c_q.snap} : '1; // R14 R17

   // Byte engine, acts at each SCL fall
   always_comb begin
      l_d = l_q;
      l_d.ack_s = {l_q.ack_s[0], c_q.ack};
      l_d.seen = start_tgl_q;
      if (start_w) begin
         // New request, also after a repeated start
         l_d.st = prd_pkg::DEV_ADDR; // R6
         l_d.cnt = '0;
         l_d.sda_oe_n = 1'b1;
         l_d.req = ~l_q.req; // R17
      end else begin
         unique case (l_q.st)
            prd_pkg::DEV_IDLE, prd_pkg::DEV_IGNORE: begin
               l_d.sda_oe_n = 1'b1; // R2 R3
            end
            prd_pkg::DEV_ADDR: begin
               // Bits sampled at SCL rise, MSB first
               l_d.cnt = l_q.cnt + 1'b1; // R7 R8
               if (l_q.cnt != 3'd7) begin
                  l_d.sh = {l_q.sh[AW-2:0], sda_hi_q}; // R8
               end else if (hit_w) begin
                  l_d.rd = (sda_hi_q == prd_pkg::DIR_RD);
                  l_d.sda_oe_n = 1'b0; // R9
                  l_d.st = prd_pkg::DEV_AACK;
               end else begin
                  l_d.st = prd_pkg::DEV_IGNORE; // R18
               end
            end
            prd_pkg::DEV_AACK: begin
               l_d.cnt = '0;
               l_d.byt = 1'b0;
               if (l_q.rd) begin
                  // First data bit goes out in the low phase
                  l_d.tx = word_w; // R14
                  l_d.sda_oe_n = word_w[TW-1]; // R7
                  l_d.st = prd_pkg::DEV_TX;
               end else begin
                  l_d.sda_oe_n = 1'b1;
                  l_d.st = prd_pkg::DEV_IGNORE;
               end
            end
            prd_pkg::DEV_TX: begin
               if (l_q.cnt == 3'd7) begin
                  // Free SDA for the master's acknowledge
                  l_d.sda_oe_n = 1'b1; // R9
                  l_d.st = prd_pkg::DEV_MACK;
               end else begin
                  l_d.cnt = l_q.cnt + 1'b1;
                  l_d.tx = {l_q.tx[TW-2:0], 1'b0}; // R8
                  l_d.sda_oe_n = l_q.tx[TW-2]; // R7
               end
            end
            prd_pkg::DEV_MACK: begin
               l_d.cnt = '0;
               if ((sda_hi_q == prd_pkg::ACK_BIT) && !l_q.byt) begin
                  // Low byte follows the high byte
                  l_d.byt = 1'b1; // R14
                  l_d.tx = {l_q.tx[TW-2:0], 1'b0};
                  l_d.sda_oe_n = l_q.tx[TW-2];
                  l_d.st = prd_pkg::DEV_TX;
               end else begin
                  // Missed acknowledge or both bytes sent
                  l_d.sda_oe_n = 1'b1; // R10
                  l_d.st = prd_pkg::DEV_IGNORE;
               end
            end
            default: begin
               l_d.st = prd_pkg::DEV_IDLE;
               l_d.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   // Link domain registers
   always_ff @(negedge link.scl or negedge nrst_i) begin
      if (!nrst_i) begin
         l_q <= '{st: prd_pkg::DEV_IDLE, sda_oe_n: 1'b1, default: '0};
      end else begin
         l_q <= l_d;
      end
   end

   // Outputs
   assign pres_out_o = c_q.outv;
   assign conv_done_o = c_q.done;
   assign link.s_sda_o = 1'b0;
   assign link.s_sda_oe_n = l_q.sda_oe_n;

endmodule

// ### rtl/prd_master.sv
`timescale 1ns/1ps
module prd_fifo #(
   parameter int unsigned WIDTH = prd_pkg::TX_W,
   parameter int unsigned DEPTH = prd_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side, registered
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int unsigned AW = $clog2(DEPTH);

   // Buffer state
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } prd_fifo_s;

   prd_fifo_s f_q;
   prd_fifo_s f_d;
   logic push_w;
   logic pop_w;
   logic take_w;

   assign in_ready_o = (f_q.cnt != (AW + 1)'(DEPTH));
   assign push_w = in_valid_i & in_ready_o;
   assign take_w = f_q.ov & out_ready_i;
   assign pop_w = (f_q.cnt != '0) & (~f_q.ov | take_w);

   // Write, refill output stage, count
   always_comb begin
      f_d = f_q;
      if (take_w) begin
         f_d.ov = 1'b0;
      end
      if (push_w) begin
         f_d.mem[f_q.wr] = in_data_i;
         f_d.wr = f_q.wr + 1'b1;
      end
      if (pop_w) begin
         f_d.od = f_q.mem[f_q.rd];
         f_d.ov = 1'b1;
         f_d.rd = f_q.rd + 1'b1;
      end
      f_d.cnt = f_q.cnt + (AW + 1)'(push_w) - (AW + 1)'(pop_w);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end

   assign out_valid_o = f_q.ov;
   assign out_data_o = f_q.od;

endmodule

module prd_master #(
   parameter int unsigned QUARTER = prd_pkg::SCL_QUARTER_CYCLES,
   parameter int unsigned DEPTH = prd_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Polling control
   input wire logic run_i,
   input wire logic [prd_pkg::ADDR_W-1:0] addr_i,
   // Pressure words
   output logic rd_valid_o,
   output logic [prd_pkg::TX_W-1:0] rd_data_o,
   input wire logic rd_ready_i,
   // Status
   output logic nack_o,
   output logic busy_o,
   // Two-wire bus, master end
   prd_link_if.master link
);

   localparam int unsigned DW = $clog2(QUARTER);
   localparam int unsigned BW = prd_pkg::BYTE_W;

   // Engine state
   typedef struct packed {
      prd_pkg::prd_mst_st_e st;
      logic [1:0] ph;
      logic [DW-1:0] div;
      logic [3:0] bitn;
      logic [1:0] byt;
      logic [BW:0] sh;
      logic [BW-1:0] hi;
      logic [prd_pkg::ADDR_W-1:0] adr;
      logic [1:0] sda_s;
      logic scl_oe_n;
      logic sda_oe_n;
      logic nack;
      logic busy;
   } prd_mst_s;

   prd_mst_s m_q;
   prd_mst_s m_d;
   logic tick_w;
   logic push_w;
   logic room_w;
   logic [prd_pkg::TX_W-1:0] word_w;

   assign tick_w = (m_q.div == '0);

   // Bus sequencer, four quarters per bit
   always_comb begin
      m_d = m_q;
      push_w = 1'b0;
      word_w = {m_q.hi, m_q.sh[BW-1:0]};
      m_d.sda_s = {m_q.sda_s[0], link.sda};
      m_d.nack = 1'b0;
      if (m_q.st != prd_pkg::MST_IDLE) begin
         m_d.div = tick_w ? DW'(QUARTER - 1) : m_q.div - 1'b1; // R15
         m_d.ph = tick_w ? m_q.ph + 1'b1 : m_q.ph;
      end
      unique case (m_q.st)
         prd_pkg::MST_IDLE: begin
            m_d.scl_oe_n = 1'b1; // R3
            m_d.sda_oe_n = 1'b1; // R3
            m_d.busy = 1'b0;
            if (run_i && room_w) begin
               m_d.st = prd_pkg::MST_START;
               m_d.ph = '0;
               m_d.div = DW'(QUARTER - 1);
               m_d.adr = addr_i;
               m_d.busy = 1'b1;
            end
         end
         prd_pkg::MST_START: begin
            if (tick_w && m_q.ph == 2'd1) begin
               m_d.sda_oe_n = 1'b0; // R4
            end
            if (tick_w && m_q.ph == 2'd3) begin
               m_d.scl_oe_n = 1'b0;
               m_d.st = prd_pkg::MST_XFER;
               m_d.bitn = '0;
               m_d.byt = '0;
               m_d.sh = {m_q.adr, prd_pkg::DIR_RD, prd_pkg::NACK_BIT}; // R13
            end
         end
         prd_pkg::MST_XFER: begin
            if (tick_w && m_q.ph == 2'd0) begin
               m_d.sda_oe_n = m_q.sh[BW]; // R7 R8
            end
            if (tick_w && m_q.ph == 2'd1) begin
               m_d.scl_oe_n = 1'b1;
            end
            if (tick_w && m_q.ph == 2'd3) begin
               m_d.scl_oe_n = 1'b0;
               m_d.sh = {m_q.sh[BW-1:0], m_q.sda_s[1]};
               m_d.bitn = m_q.bitn + 1'b1;
               if (m_q.bitn == 4'd8) begin
                  m_d.bitn = '0;
                  m_d.byt = m_q.byt + 1'b1;
                  // Acknowledge only the first data byte
                  m_d.sh = {{BW{1'b1}}, (m_q.byt == 2'd0) ? prd_pkg::ACK_BIT : prd_pkg::NACK_BIT}; // R9 R10
                  if (m_q.byt == 2'd0 && m_q.sda_s[1] == prd_pkg::NACK_BIT) begin
                     m_d.nack = 1'b1;
                     m_d.st = prd_pkg::MST_STOP; // R10
                  end
                  if (m_q.byt == 2'd1) begin
                     m_d.hi = m_q.sh[BW-1:0]; // R14
                  end
                  if (m_q.byt == 2'd2) begin
                     push_w = 1'b1;
                     m_d.st = prd_pkg::MST_RSTART;
                  end
               end
            end
         end
         prd_pkg::MST_RSTART: begin
            if (tick_w && m_q.ph == 2'd0) begin
               if (run_i && room_w) begin
                  m_d.sda_oe_n = 1'b1; // R6
               end else begin
                  m_d.sda_oe_n = 1'b0;
                  m_d.st = prd_pkg::MST_STOP;
               end
            end
            if (tick_w && m_q.ph == 2'd1) begin
               m_d.scl_oe_n = 1'b1;
            end
            if (tick_w && m_q.ph == 2'd3) begin
               m_d.st = prd_pkg::MST_START;
            end
         end
         prd_pkg::MST_STOP: begin
            if (tick_w && m_q.ph == 2'd0) begin
               m_d.sda_oe_n = 1'b0;
            end
            if (tick_w && m_q.ph == 2'd1) begin
               m_d.scl_oe_n = 1'b1;
            end
            if (tick_w && m_q.ph == 2'd3) begin
               m_d.sda_oe_n = 1'b1; // R5
               m_d.st = prd_pkg::MST_IDLE;
            end
         end
         default: begin
            m_d.st = prd_pkg::MST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         m_q <= '{st: prd_pkg::MST_IDLE, sda_s: 2'h3, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};
      end else begin
         m_q <= m_d;
      end
   end

   // Received words, reads pause while full
   prd_fifo #(
      .WIDTH(prd_pkg::TX_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .in_valid_i(push_w),
      .in_data_i(word_w),
      .in_ready_o(room_w),
      .out_valid_o(rd_valid_o),
      .out_data_o(rd_data_o),
      .out_ready_i(rd_ready_i)
   );

   // Outputs
   assign nack_o = m_q.nack;
   assign busy_o = m_q.busy;
   assign link.m_scl_o = 1'b0;
   assign link.m_sda_o = 1'b0;
   assign link.m_scl_oe_n = m_q.scl_oe_n;
   assign link.m_sda_oe_n = m_q.sda_oe_n;

endmodule

// ### sim/prd_link_monitor.sv
`timescale 1ns/1ps
module prd_link_monitor #(
   parameter int unsigned QUARTER = 8
) (
   // Core clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Link wires and drivers
   input wire logic scl,
   input wire logic sda,
   input wire logic m_scl_oe_n,
   input wire logic m_sda_oe_n,
   input wire logic s_sda_oe_n
);
   logic scl_q;
   logic sda_q;
   logic busy_q;
   logic [3:0] bitn_q;
   logic [1:0] byten_q;
   logic [7:0] sh_q;
   logic [15:0] hi_q;
   logic start;
   logic stop;
   logic rise;

   // Bus events against the previous sample
   assign start = scl_q & scl & sda_q & ~sda;
   assign stop = scl_q & scl & ~sda_q & sda;
   assign rise = ~scl_q & scl;

   // Bit and byte position since the last start
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         busy_q <= 1'b0;
         bitn_q <= 4'h0;
         byten_q <= 2'h0;
         sh_q <= 8'h00;
         hi_q <= 16'h0000;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         hi_q <= !scl ? 16'h0000 : (hi_q == 16'hffff ? hi_q : hi_q + 16'h0001);
         if (start) begin
            busy_q <= 1'b1;
            bitn_q <= 4'h0;
            byten_q <= 2'h0;
         end else if (stop) begin
            busy_q <= 1'b0;
         end else if (rise && bitn_q == 4'h8) begin
            bitn_q <= 4'h0;
            byten_q <= byten_q + {1'b0, byten_q != 2'h3};
         end else if (rise) begin
            sh_q <= {sh_q[6:0], sda};
            bitn_q <= bitn_q + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   a_idle_high: assert property (!busy_q && !start |-> scl && sda)
      else $error("idle bus not high");
   a_dev_silent: assert property (!busy_q |-> s_sda_oe_n)
      else $error("device drives idle bus");
   a_dev_hold_high: assert property (scl && scl_q |-> $stable(s_sda_oe_n))
      else $error("device sda moved while scl high");
   a_addr_ack: assert property (rise && bitn_q == 4'h8 && byten_q == 2'h0 && sh_q[7:1] == prd_pkg::ADDR_PRIMARY |-> !sda)
      else $error("own address not acknowledged");
   a_addr_refuse: assert property (rise && bitn_q == 4'h8 && byten_q == 2'h0 && sh_q[7:1] != prd_pkg::ADDR_PRIMARY |-> sda)
      else $error("foreign address acknowledged");
   a_mack_slot: assert property (rise && bitn_q == 4'h8 && byten_q != 2'h0 |-> s_sda_oe_n)
      else $error("device drives master ack slot");
   a_nack_release: assert property (rise && bitn_q == 4'h8 && byten_q != 2'h1 && sda |=> s_sda_oe_n [*8])
      else $error("device drives after nack");
   a_scl_high_len: assert property (!scl && scl_q && (bitn_q != 4'h0 || byten_q != 2'h0) |-> hi_q == 2 * QUARTER)
      else $error("scl high phase wrong length");
   a_one_driver: assert property (scl |-> !(!m_sda_oe_n && !s_sda_oe_n))
      else $error("both ends pull sda");

   c_full_read: cover property (rise && bitn_q == 4'h8 && byten_q == 2'h2);
   c_rep_start: cover property (start && busy_q);
   c_refused: cover property (rise && bitn_q == 4'h8 && byten_q == 2'h0 && sda);
endmodule

// ### sim/pressure_i2c_readout_tb.sv
`timescale 1ns/1ps
module pressure_i2c_readout_tb;
   localparam int unsigned CONV = 64;
   localparam int unsigned QTR = 8;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b1;
   logic [prd_pkg::PRES_W-1:0] pressure_i = 13'h0000;
   logic run_i = 1'b0;
   logic [prd_pkg::ADDR_W-1:0] addr_i = prd_pkg::ADDR_PRIMARY;
   logic rd_ready_i = 1'b0;
   logic [prd_pkg::PRES_W-1:0] pres_out_o;
   logic conv_done_o;
   logic rd_valid_o;
   logic [prd_pkg::TX_W-1:0] rd_data_o;
   logic nack_o;
   logic busy_o;
   int n_fail = 0;
   int tests_run = 0;
   int seed = 50;
   int n_rd = 0;
   int n_nack = 0;
   int cyc = 0;
   int last_tick = -1;
   int rdy_mode = 0;
   logic [12:0] hist[$];
   logic [25:0] snap[$];
   logic [6:0] bad[4];

   // Core clock
   always #5 clk_sys_i = ~clk_sys_i;

   prd_link_if lk();
   prd_device #(.CONV_CYCLES(CONV)) prd_device_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .pressure_i(pressure_i), .pres_out_o(pres_out_o), .conv_done_o(conv_done_o), .link(lk.device));
   prd_master #(.QUARTER(QTR)) prd_master_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .run_i(run_i),
      .addr_i(addr_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i),
      .nack_o(nack_o), .busy_o(busy_o), .link(lk.master));
   prd_link_monitor #(.QUARTER(QTR)) prd_link_monitor_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .scl(lk.scl), .sda(lk.sda), .m_scl_oe_n(lk.m_scl_oe_n), .m_sda_oe_n(lk.m_sda_oe_n),
      .s_sda_oe_n(lk.s_sda_oe_n));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Word layout: three zero bits over the value
   function automatic logic [15:0] word_of(input logic [12:0] v);
      return {3'b000, v};
   endfunction

   task automatic finish_test;
      if (n_fail == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wait_rd(input int n);
      for (int i = 0; i < 40000 && n_rd < n; i++) @(posedge clk_sys_i);
      if (n_rd < n) chk(16'(n_rd), 16'(n));
   endtask

   task automatic restart(input logic [6:0] a);
      #1 run_i = 1'b0;
      for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      #1 addr_i = a;
      run_i = 1'b1;
   endtask

   // Conversion spacing and pipeline delay, new random sample per tick
   always @(posedge clk_sys_i) begin
      cyc++;
      if (!nrst_i) begin
         hist.delete();
         last_tick = -1;
      end else if (conv_done_o === 1'b1) begin
         if (last_tick >= 0) chk(16'(cyc - last_tick), 16'(CONV));
         chk(16'(pres_out_o), hist.size() >= 4 ? 16'(hist[hist.size()-4]) : 16'h0000);
         hist.push_back(pressure_i);
         last_tick = cyc;
         // New sample only once the design has taken the old one
         #1 pressure_i = 13'($random(seed));
      end
   end

   // Output value around each start of a read
   always @(negedge lk.sda) begin
      logic [12:0] a;
      if (lk.scl === 1'b1 && nrst_i && addr_i == prd_pkg::ADDR_PRIMARY) begin
         a = pres_out_o;
         // Value standing when the core freezes its snapshot
         repeat (19) @(posedge clk_sys_i);
         snap.push_back({a, pres_out_o});
      end
   end

   // Word sink with selectable back-pressure
   always @(posedge clk_sys_i) begin
      logic [25:0] s;
      if (rd_valid_o === 1'b1 && rd_ready_i && nrst_i) begin
         s = snap.size() > 0 ? snap.pop_front() : 26'h0;
         if (rd_data_o === word_of(s[12:0])) chk(rd_data_o, word_of(s[12:0]));
         else chk(rd_data_o, word_of(s[25:13]));
         n_rd++;
      end
      if (nack_o === 1'b1) n_nack++;
      #1 rd_ready_i = rdy_mode == 2 || (rdy_mode == 1 && ($random(seed) & 1) == 1);
   end

   // Watchdog
   initial begin
      #900000;
      n_fail++;
      finish_test;
   end

   initial begin
      int n;
      #1 nrst_i = 1'b0;
      repeat (20) @(posedge clk_sys_i);
      #1 nrst_i = 1'b1;
      chk({14'h0, lk.scl, lk.sda}, 16'h0003);
      // Polling with repeated starts and random back-pressure
      rdy_mode = 1;
      run_i = 1'b1;
      wait_rd(12);
      // Stall the sink until the buffer refuses, then drain
      rdy_mode = 0;
      repeat (20 * 28 * 4 * QTR) @(posedge clk_sys_i);
      chk(16'(snap.size()), 16'd17);
      rdy_mode = 2;
      wait_rd(n_rd + 20);
      // Foreign addresses, one-bit neighbours and the disabled secondary
      bad[0] = 7'h79;
      bad[1] = 7'h38;
      bad[2] = prd_pkg::SEC_ADDR_DEF;
      bad[3] = 7'($random(seed)) ^ 7'h01;
      if (bad[3] == prd_pkg::ADDR_PRIMARY) bad[3] = 7'h00;
      foreach (bad[i]) begin
         restart(bad[i]);
         n = n_nack;
         for (int j = 0; j < 2000 && n_nack == n; j++) @(posedge clk_sys_i);
         chk(16'(n_nack != n), 16'h0001);
      end
      n = n_rd;
      restart(prd_pkg::ADDR_PRIMARY);
      chk(16'(n_rd), 16'(n));
      wait_rd(n_rd + 3);
      // Reset in mid-transfer releases the bus
      repeat (300) @(posedge clk_sys_i);
      #1 nrst_i = 1'b0;
      repeat (20) @(posedge clk_sys_i);
      #1 chk({3'h0, pres_out_o}, 16'h0000);
      chk({14'h0, lk.scl, lk.sda}, 16'h0003);
      snap.delete();
      nrst_i = 1'b1;
      wait_rd(n_rd + 3);
      finish_test;
   end
endmodule
